// [include/exposure_if.sv]
// Carrier between the sequencer and its exposure timer
`timescale 1ns/1ps
`default_nettype none
interface exposure_if;
   logic arm;
   logic [scan_pkg::EXPO_W-1:0] exposure_cycles;
   logic idle;
   logic shutter;
   logic expired;
   modport timer (input arm, input exposure_cycles, output idle, output shutter, output expired);
   modport seq (output arm, output exposure_cycles, input idle, input shutter, input expired);
endinterface : exposure_if
`default_nettype wire

// [include/scan_pkg.sv]
// Constants and types shared by the scan sequencer files
package scan_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_SHUTTER_PS = 3000000;
   localparam int T_TRANSFER_PS = 3000000;
   localparam int T_VSHIFT_PS = 1300000;
   localparam int SHUTTER_CYCLES = (T_SHUTTER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TRANSFER_CYCLES = (T_TRANSFER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int VSHIFT_CYCLES = (T_VSHIFT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LINE_CYCLES_DEFAULT = 1000;
   // ------------------------------------------------------------
   // Row counts and widths
   // ------------------------------------------------------------
   localparam int ROWS_PROGRESSIVE = 2048;
   localparam int ROWS_INTERLACED = 1037;
   localparam int ROW_W = 12;
   localparam int LINE_W = 16;
   localparam int EXPO_W = 32;
   // ------------------------------------------------------------
   // Readout modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_PROGRESSIVE = 2'h0,
      MODE_SUMMED = 2'h1,
      MODE_NON_SUMMED = 2'h2,
      MODE_RESERVED = 2'h3
   } scan_mode_t;
endpackage : scan_pkg

// [rtl/exposure_timer.sv]
// Shutter pulse and exposure interval timer
`timescale 1ns/1ps
`default_nettype none
module exposure_timer (
   input wire logic clk,
   input wire logic reset,
   exposure_if.timer ctl
);
   typedef enum logic [1:0] {
      T_IDLE = 2'h0,
      T_RUN = 2'h1
   } timer_state_t;

   timer_state_t state;
   timer_state_t next_state;
   logic [scan_pkg::EXPO_W-1:0] count;
   logic [scan_pkg::EXPO_W-1:0] next_count;
   logic [scan_pkg::EXPO_W-1:0] target;
   logic [scan_pkg::EXPO_W-1:0] next_target;
   logic shutter;
   logic next_shutter;

   localparam logic [scan_pkg::EXPO_W-1:0] SHUT_LEN = scan_pkg::EXPO_W'(scan_pkg::SHUTTER_CYCLES);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_count = count;
      next_target = target;
      next_shutter = 1'b0;
      unique case (state)
         T_IDLE: begin
            if (ctl.arm) begin
               next_state = T_RUN;
               next_count = '0;
               next_shutter = 1'b1;
               // Exposure never shorter than the shutter pulse plus one cycle
               next_target = (ctl.exposure_cycles > SHUT_LEN) ? ctl.exposure_cycles : SHUT_LEN + 1'b1;
            end
         end
         T_RUN: begin
            next_count = count + 1'b1;
            next_shutter = (count + 1'b1) < SHUT_LEN;
            if (count == target - 1'b1) begin
               next_state = T_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= T_IDLE;
         count <= '0;
         target <= '0;
         shutter <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         target <= next_target;
         shutter <= next_shutter;
      end
   end

   assign ctl.idle = (state == T_IDLE);
   assign ctl.shutter = shutter;
   // Fires one cycle before the transfer edge is due
   assign ctl.expired = (state == T_RUN) && (count == target - 1'b1);
endmodule : exposure_timer
`default_nettype wire

// [rtl/scan_sequencer.sv]
// Readout-mode and exposure sequencer driving an interline sensor
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer #(
   parameter int LINE_CYCLES = scan_pkg::LINE_CYCLES_DEFAULT,
   parameter int ROWS_PROG = scan_pkg::ROWS_PROGRESSIVE,
   parameter int ROWS_INTL = scan_pkg::ROWS_INTERLACED
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [1:0] scan_mode,
   input wire logic field_odd,
   input wire logic [scan_pkg::EXPO_W-1:0] exposure_cycles,
   output logic start_ready,
   output logic shutter_pulse_clock,
   output logic vertical_phase_two,
   output logic transfer_even_rows,
   output logic transfer_odd_rows,
   output logic sum_pair_offset,
   output logic vertical_shift,
   output logic [scan_pkg::ROW_W-1:0] row_index,
   output logic readout_busy,
   output logic field_done,
   output logic overrun
);
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_WAIT = 2'h1,
      S_XFER = 2'h2,
      S_READ = 2'h3
   } seq_state_t;

   localparam logic [scan_pkg::LINE_W-1:0] XFER_LAST = scan_pkg::LINE_W'(scan_pkg::TRANSFER_CYCLES - 1);
   localparam logic [scan_pkg::LINE_W-1:0] LINE_LAST = scan_pkg::LINE_W'(LINE_CYCLES - 1);
   localparam logic [scan_pkg::LINE_W-1:0] VSHIFT_LEN = scan_pkg::LINE_W'(scan_pkg::VSHIFT_CYCLES);
   localparam logic [scan_pkg::ROW_W-1:0] ROWS_PROG_LAST = scan_pkg::ROW_W'(ROWS_PROG - 1);
   localparam logic [scan_pkg::ROW_W-1:0] ROWS_INTL_LAST = scan_pkg::ROW_W'(ROWS_INTL - 1);

   exposure_if expo ();

   exposure_timer u_timer (
      .clk(clk),
      .reset(reset),
      .ctl(expo.timer)
   );

   seq_state_t state;
   seq_state_t next_state;
   logic [scan_pkg::LINE_W-1:0] tick;
   logic [scan_pkg::LINE_W-1:0] next_tick;
   logic [scan_pkg::ROW_W-1:0] row;
   logic [scan_pkg::ROW_W-1:0] next_row;
   logic [scan_pkg::ROW_W-1:0] row_last;
   logic [scan_pkg::ROW_W-1:0] next_row_last;
   scan_pkg::scan_mode_t mode;
   scan_pkg::scan_mode_t next_mode;
   logic odd;
   logic next_odd;
   logic pending;
   logic next_pending;
   logic v2;
   logic next_v2;
   logic even_sel;
   logic next_even_sel;
   logic odd_sel;
   logic next_odd_sel;
   logic pair_off;
   logic next_pair_off;
   logic vshift;
   logic next_vshift;
   logic done;
   logic next_done;
   logic late;
   logic next_late;
   logic accept;

   // ------------------------------------------------------------
   // Start handshake
   // ------------------------------------------------------------
   // A new exposure may begin during readout of the previous field
   assign start_ready = expo.idle && !pending && (state == S_IDLE || state == S_READ);
   assign accept = start && start_ready;
   assign expo.arm = accept;
   assign expo.exposure_cycles = exposure_cycles;

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_tick = tick;
      next_row = row;
      next_row_last = row_last;
      next_mode = mode;
      next_odd = odd;
      next_pending = pending;
      next_v2 = 1'b0;
      next_even_sel = even_sel;
      next_odd_sel = odd_sel;
      next_pair_off = pair_off;
      next_vshift = 1'b0;
      next_done = 1'b0;
      next_late = 1'b0;
      if (accept) begin
         // Mode and field are captured with the exposure they belong to
         next_mode = (scan_mode == 2'h3) ? scan_pkg::MODE_PROGRESSIVE : scan_pkg::scan_mode_t'(scan_mode);
         next_odd = field_odd;
      end
      unique case (state)
         S_IDLE: begin
            if (accept) begin
               next_state = S_WAIT;
            end
         end
         S_WAIT: begin
            // A late transfer launches as soon as the readout has ended
            if (expo.expired || pending) begin
               next_state = S_XFER;
               next_pending = 1'b0;
               next_tick = '0;
               next_v2 = 1'b1;
               unique case (mode)
                  scan_pkg::MODE_SUMMED: begin
                     next_even_sel = 1'b1;
                     next_odd_sel = 1'b1;
                     next_pair_off = odd;
                     next_row_last = ROWS_INTL_LAST;
                  end
                  scan_pkg::MODE_NON_SUMMED: begin
                     next_even_sel = !odd;
                     next_odd_sel = odd;
                     next_pair_off = 1'b0;
                     next_row_last = ROWS_INTL_LAST;
                  end
                  default: begin
                     next_even_sel = 1'b1;
                     next_odd_sel = 1'b1;
                     next_pair_off = 1'b0;
                     next_row_last = ROWS_PROG_LAST;
                  end
               endcase
            end
         end
         S_XFER: begin
            next_tick = tick + 1'b1;
            next_v2 = (tick != XFER_LAST);
            if (tick == XFER_LAST) begin
               next_state = S_READ;
               next_tick = '0;
               next_row = '0;
               next_vshift = 1'b1;
            end
         end
         S_READ: begin
            next_tick = tick + 1'b1;
            next_vshift = (tick + 1'b1) < VSHIFT_LEN;
            if (expo.expired) begin
               // Exposure ran out before the register emptied: transfer is late
               next_pending = 1'b1;
               next_late = 1'b1;
            end
            if (tick == LINE_LAST) begin
               next_tick = '0;
               next_vshift = 1'b1;
               next_row = row + 1'b1;
               if (row == row_last) begin
                  next_vshift = 1'b0;
                  next_done = 1'b1;
                  if (pending || expo.expired) begin
                     // Timer expires now or expired earlier in the readout: keep the late flag for the wait state
                     next_state = S_WAIT;
                     next_pending = 1'b1;
                  end else if (!expo.idle || accept) begin
                     next_state = S_WAIT;
                  end else begin
                     next_state = S_IDLE;
                  end
               end
            end else if (accept) begin
               next_pending = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= S_IDLE;
         tick <= '0;
         row <= '0;
         row_last <= '0;
         mode <= scan_pkg::MODE_PROGRESSIVE;
         odd <= 1'b0;
         pending <= 1'b0;
         v2 <= 1'b0;
         even_sel <= 1'b0;
         odd_sel <= 1'b0;
         pair_off <= 1'b0;
         vshift <= 1'b0;
         done <= 1'b0;
         late <= 1'b0;
      end else begin
         state <= next_state;
         tick <= next_tick;
         row <= next_row;
         row_last <= next_row_last;
         mode <= next_mode;
         odd <= next_odd;
         pending <= next_pending;
         v2 <= next_v2;
         even_sel <= next_even_sel;
         odd_sel <= next_odd_sel;
         pair_off <= next_pair_off;
         vshift <= next_vshift;
         done <= next_done;
         late <= next_late;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign shutter_pulse_clock = expo.shutter;
   assign vertical_phase_two = v2;
   assign transfer_even_rows = even_sel;
   assign transfer_odd_rows = odd_sel;
   assign sum_pair_offset = pair_off;
   assign vertical_shift = vshift;
   assign row_index = row;
   assign readout_busy = (state == S_READ);
   assign field_done = done;
   assign overrun = late;
endmodule : scan_sequencer
`default_nettype wire

// [testbench/scan_checker.sv]
// Port assertions for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module scan_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [1:0] scan_mode,
   input wire logic field_odd,
   input wire logic [scan_pkg::EXPO_W-1:0] exposure_cycles,
   input wire logic start_ready,
   input wire logic shutter_pulse_clock,
   input wire logic vertical_phase_two,
   input wire logic transfer_even_rows,
   input wire logic transfer_odd_rows,
   input wire logic sum_pair_offset,
   input wire logic vertical_shift,
   input wire logic [scan_pkg::ROW_W-1:0] row_index,
   input wire logic readout_busy,
   input wire logic field_done,
   input wire logic overrun
);
   // ------------------------------------------------------------
   // Pulse widths, exposure gap and captured request
   // ------------------------------------------------------------
   logic [15:0] s_cnt, p_cnt, next_s_cnt, next_p_cnt;
   logic [31:0] gap, expo, next_gap, next_expo;
   logic [1:0] mode, next_mode;
   logic fodd, late, next_fodd, next_late;
   always_comb begin
      next_s_cnt = shutter_pulse_clock ? s_cnt + 16'h1 : 16'h0;
      next_p_cnt = vertical_phase_two ? p_cnt + 16'h1 : 16'h0;
      next_gap = (shutter_pulse_clock && s_cnt == 16'h0) ? 32'h1 : gap + 32'h1;
      next_expo = expo;
      next_mode = mode;
      next_fodd = fodd;
      if (start && start_ready) begin
         next_expo = (exposure_cycles <= scan_pkg::SHUTTER_CYCLES) ? 32'h259 : exposure_cycles;
         next_mode = scan_mode;
         next_fodd = field_odd;
      end
      next_late = overrun ? 1'b1 : ((vertical_phase_two && p_cnt == 16'h0) ? 1'b0 : late);
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         {s_cnt, p_cnt, gap, expo, mode, fodd, late} <= '0;
      end else begin
         {s_cnt, p_cnt, gap, expo} <= {next_s_cnt, next_p_cnt, next_gap, next_expo};
         {mode, fodd, late} <= {next_mode, next_fodd, next_late};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_accept; start && start_ready; endsequence
   sequence s_vs_hi; ##259 vertical_shift ##1 !vertical_shift; endsequence
   property p_shut_rise; s_accept |=> $rose(shutter_pulse_clock); endproperty
   property p_shut_len; $fell(shutter_pulse_clock) |-> s_cnt == scan_pkg::SHUTTER_CYCLES; endproperty
   property p_expo; $rose(vertical_phase_two) && !late |-> gap == expo; endproperty
   property p_p2_len; $fell(vertical_phase_two) |-> p_cnt == scan_pkg::TRANSFER_CYCLES; endproperty
   property p_sel;
      $rose(vertical_phase_two) |=> {transfer_even_rows, transfer_odd_rows, sum_pair_offset} ==
         {mode != 2'h2 || !fodd, mode != 2'h2 || fodd, mode == 2'h1 && fodd};
   endproperty
   property p_read_go; $fell(vertical_phase_two) |-> ##[0:1] (vertical_shift && readout_busy && row_index == 12'h0);
   endproperty
   property p_vs_len; $rose(vertical_shift) |-> s_vs_hi; endproperty
   property p_done; field_done |=> !field_done && !readout_busy; endproperty
   a_shut_rise: assert property (p_shut_rise) else $error("no shutter after accept");
   a_shut_len: assert property (p_shut_len) else $error("shutter width wrong");
   a_expo: assert property (p_expo) else $error("exposure gap wrong");
   a_p2_len: assert property (p_p2_len) else $error("transfer width wrong");
   a_sel: assert property (p_sel) else $error("row select wrong");
   a_read_go: assert property (p_read_go) else $error("readout did not start");
   a_vs_len: assert property (p_vs_len) else $error("shift pulse width wrong");
   a_done: assert property (p_done) else $error("done pulse wrong");
endmodule : scan_checker
`default_nettype wire

// [testbench/sensor_model.sv]
// Behavioural model of the sensor at the clock pins
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
   input wire logic clk,
   input wire logic shutter,
   input wire logic phase_two,
   input wire logic even_rows,
   input wire logic odd_rows,
   input wire logic pair_offset,
   input wire logic vshift,
   output int empties,
   output int expo_seen,
   output logic [2:0] xfer,
   output int shifts
);
   logic sh_q = 1'b0;
   logic p2_q = 1'b0;
   logic vs_q = 1'b0;
   int since = 0;
   initial begin
      {empties, expo_seen, shifts} = '0;
      xfer = 3'h0;
   end
   always @(posedge clk) begin
      sh_q <= shutter;
      p2_q <= phase_two;
      vs_q <= vshift;
      if (shutter && !sh_q) begin // Substrate pulse empties all photodiodes
         empties <= empties + 1;
         since <= 1;
      end else since <= since + 1;
      if (phase_two && !p2_q) begin // All selected rows move at once
         expo_seen <= since;
         xfer <= {even_rows, odd_rows, pair_offset}; // Pair start row
         shifts <= 0;
      end else if (vshift && !vs_q) shifts <= shifts + 1; // Two cells per packet
   end
endmodule : sensor_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, reset = 1'b1, start = 1'b0, field_odd = 1'b0;
   logic [1:0] scan_mode = 2'h0;
   logic [31:0] exposure_cycles = 32'h0;
   logic start_ready, shutter_pulse_clock, vertical_phase_two, transfer_even_rows, transfer_odd_rows;
   logic sum_pair_offset, vertical_shift, readout_busy, field_done, overrun;
   logic [11:0] row_index;
   logic [2:0] xfer;
   int errors = 0, cmp_count = 0, cycles = 0, empties, expo_seen, shifts, e0, o0;
   int ovr_n = 0;
   always #2.5 clk = ~clk;
   scan_sequencer #(.LINE_CYCLES(300), .ROWS_PROG(4), .ROWS_INTL(3)) dut_u (.clk, .reset, .start, .scan_mode,
      .field_odd, .exposure_cycles, .start_ready, .shutter_pulse_clock, .vertical_phase_two, .transfer_even_rows,
      .transfer_odd_rows, .sum_pair_offset, .vertical_shift, .row_index, .readout_busy, .field_done, .overrun);
   sensor_model model_u (.clk, .shutter(shutter_pulse_clock), .phase_two(vertical_phase_two),
      .even_rows(transfer_even_rows), .odd_rows(transfer_odd_rows), .pair_offset(sum_pair_offset),
      .vshift(vertical_shift), .empties, .expo_seen, .xfer, .shifts);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   task automatic issue(input logic [1:0] m, input logic f, input logic [31:0] e);
      while (start_ready !== 1'b1) step();
      {scan_mode, field_odd, exposure_cycles, start} = {m, f, e, 1'b1};
      step();
      start = 1'b0;
   endtask : issue
   task automatic wait_done;
      step();
      while (field_done !== 1'b1) step();
   endtask : wait_done
   task automatic wait_busy;
      while (readout_busy !== 1'b1) step();
   endtask : wait_busy
   task automatic field(input logic [1:0] m, input logic f, input int e, input logic [2:0] code, input int rows);
      e0 = empties;
      issue(m, f, e);
      wait_done();
      check(expo_seen, (e <= 600) ? 601 : e);
      check(xfer, code);
      check(shifts, rows);
      check(empties - e0, 1);
   endtask : field
   task automatic t_progressive;
      field(2'h0, 1'b0, 700, 3'h6, 4);
      field(2'h3, 1'b1, 700, 3'h6, 4);
   endtask : t_progressive
   task automatic t_interlaced;
      field(2'h1, 1'b0, 700, 3'h6, 3);
      field(2'h1, 1'b1, 700, 3'h7, 3);
      field(2'h2, 1'b0, 900, 3'h4, 3);
      field(2'h2, 1'b1, 601, 3'h2, 3);
      field(2'h0, 1'b0, 5, 3'h6, 4);
   endtask : t_interlaced
   task automatic t_refused;
      e0 = empties;
      issue(2'h0, 1'b0, 800);
      repeat (10) step();
      check(start_ready, 1'b0);
      {scan_mode, start} = {2'h2, 1'b1};
      step();
      start = 1'b0;
      wait_done();
      check(xfer, 3'h6);
      check(empties - e0, 1);
   endtask : t_refused
   task automatic t_overlap(input int e, input logic late);
      o0 = ovr_n;
      issue(2'h0, 1'b0, 700);
      wait_busy();
      issue(2'h0, 1'b1, e);
      check(readout_busy, 1'b1);
      wait_done();
      wait_done();
      if (!late) check(expo_seen, e);
      check(ovr_n - o0, late);
      check(shifts, 4);
   endtask : t_overlap
   always @(posedge clk) begin
      if (overrun === 1'b1) ovr_n <= ovr_n + 1;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 reset = 1'b0;
      check(start_ready, 1'b1);
      t_progressive();
      t_interlaced();
      t_refused();
      t_overlap(2000, 1'b0);
      t_overlap(601, 1'b1);
      results();
   end
endmodule : tb
bind scan_sequencer scan_checker chk_u (.clk, .reset, .start, .scan_mode, .field_odd, .exposure_cycles,
   .start_ready, .shutter_pulse_clock, .vertical_phase_two, .transfer_even_rows, .transfer_odd_rows,
   .sum_pair_offset, .vertical_shift, .row_index, .readout_busy, .field_done, .overrun);
`default_nettype wire
